// file: core/ifc_handler.sv
// Image feature command handler: AHB-Lite slave that interprets binning, mirror
// and test image commands written as one command word and keeps the settings.
// Assumes one AHB-Lite master on clk; this slave never inserts wait states.
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module ifc_handler
    import ifc_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic vbin_enable,
    output logic hbin_enable,
    output logic full_binning,
    output logic mirror_enable,
    output logic [1:0] test_image
);
    logic wr_pend;
    logic rd_pend;
    logic [3:0] dp_addr;
    logic rsp_valid;
    logic reject;
    logic [7:0] rsp_code;
    logic [7:0] rsp_data;

    // Address phase capture; only whole word transfers carry commands
    wire addr_go = hsel && hready && htrans[1] && (hsize == 3'h2);
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            dp_addr <= 4'h0;
        end
        else
        begin
            wr_pend <= addr_go && hwrite;
            rd_pend <= addr_go && !hwrite;
            dp_addr <= (addr_go && haddr[31:4] == 28'h0) ? haddr[3:0] : 4'h1;
        end
    end

    // Command word fields, taken from the write data phase
    wire [7:0] cmd_code = hwdata[POS_CODE +: 8];
    wire cmd_flag = hwdata[POS_FLAG];
    wire [7:0] cmd_len = hwdata[POS_LEN +: 8];
    wire [7:0] cmd_data = hwdata[POS_DATA +: 8];
    wire cmd_go = wr_pend && (dp_addr == OFS_CMD);
    wire is_vbin = cmd_code == CODE_VBIN;
    wire is_hbin = cmd_code == CODE_HBIN;
    wire is_mirror = cmd_code == CODE_MIRROR;
    wire is_test = cmd_code == CODE_TEST;
    wire known = (is_vbin || is_hbin || is_mirror || is_test) && (cmd_len == CMD_LEN);
    wire do_read = cmd_go && known && (cmd_flag == FLAG_READ);
    wire do_write = cmd_go && known && (cmd_flag == FLAG_WRITE);
    // Binary settings accept only 0x00 and 0x01; test image only 0x00 to 0x03
    wire bin_ok = (cmd_data == VAL_OFF) || (cmd_data == VAL_ON);
    wire test_ok = cmd_data <= TEST_VH;
    wire data_ok = is_test ? test_ok : bin_ok;
    wire apply = do_write && data_ok;

    // Current state of the addressed setting, as the reply byte
    wire [7:0] cur_value = is_vbin ? {7'h0, vbin_enable} :
                           is_hbin ? {7'h0, hbin_enable} :
                           is_mirror ? {7'h0, mirror_enable} :
                           {6'h0, test_image};

    // Full binning follows the values the two enables take next
    wire next_vbin = (apply && is_vbin) ? cmd_data[0] : vbin_enable;
    wire next_hbin = (apply && is_hbin) ? cmd_data[0] : hbin_enable;
    wire next_full = next_vbin && next_hbin;

    // Settings update; an undefined code leaves the old value in place
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            vbin_enable <= RST_BIN;
            hbin_enable <= RST_BIN;
            full_binning <= RST_BIN;
            mirror_enable <= RST_MIRROR;
            test_image <= RST_TEST;
        end
        else
        begin
            if (apply && is_vbin)
                vbin_enable <= cmd_data[0];
            if (apply && is_hbin)
                hbin_enable <= cmd_data[0];
            if (apply && is_mirror)
                mirror_enable <= cmd_data[0];
            if (apply && is_test)
                test_image <= cmd_data[1:0];
            full_binning <= next_full;
        end
    end

    // Reply holding; a new reply wins over a clearing read in the same cycle
    wire rsp_clear = rd_pend && (dp_addr == OFS_RSP);
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            rsp_valid <= 1'b0;
            reject <= 1'b0;
            rsp_code <= 8'h00;
            rsp_data <= 8'h00;
        end
        else
        begin
            if (do_read)
            begin
                rsp_valid <= 1'b1;
                rsp_code <= cmd_code;
                rsp_data <= cur_value;
            end
            else if (rsp_clear)
                rsp_valid <= 1'b0;
            if (cmd_go)
                reject <= !(do_read || apply);
        end
    end

    // Read data mux; the reply word always carries flag 0 and length 1
    wire [31:0] rsp_word = {rsp_data, CMD_LEN, 7'h0, FLAG_WRITE, rsp_code};
    wire [31:0] stat_word = {30'h0, reject, rsp_valid};
    wire [31:0] set_word = {26'h0, test_image, full_binning, mirror_enable,
                            hbin_enable, vbin_enable};
    assign hrdata = !rd_pend ? 32'h0 :
                    (dp_addr == OFS_RSP) ? rsp_word :
                    (dp_addr == OFS_STAT) ? stat_word :
                    (dp_addr == OFS_SET) ? set_word : 32'h0;
    // Zero wait states, always OKAY; unmapped reads return zero
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Checks; all on clk and quiet while srst holds
    sequence s_read_cmd;
        do_read;
    endsequence
    sequence s_write_cmd;
        cmd_go && (cmd_flag == FLAG_WRITE);
    endsequence
    sequence s_reject_cmd;
        cmd_go && !(do_read || apply);
    endsequence
    sequence s_reply_taken;
        rsp_clear && !do_read;
    endsequence

    a_read_reply: assert property (@(posedge clk) disable iff (srst)
        s_read_cmd |=> rsp_valid && rsp_code == $past(cmd_code)
        && rsp_data == $past(cur_value))
        else $error("read command reply wrong");
    a_write_silent: assert property (@(posedge clk) disable iff (srst)
        s_write_cmd and !rsp_clear |=> $stable(rsp_valid) && $stable(rsp_code))
        else $error("write command produced a reply");
    a_vbin_apply: assert property (@(posedge clk) disable iff (srst)
        s_write_cmd and is_vbin && cmd_len == CMD_LEN && bin_ok
        |=> vbin_enable == $past(cmd_data[0]))
        else $error("vertical binning not applied");
    a_hbin_apply: assert property (@(posedge clk) disable iff (srst)
        s_write_cmd and is_hbin && cmd_len == CMD_LEN && bin_ok
        |=> hbin_enable == $past(cmd_data[0]))
        else $error("horizontal binning not applied");
    a_mirror_apply: assert property (@(posedge clk) disable iff (srst)
        s_write_cmd and is_mirror && cmd_len == CMD_LEN && cmd_data == VAL_ON
        |=> mirror_enable ##1 mirror_enable || $past(apply))
        else $error("mirror enable not applied");
    a_test_apply: assert property (@(posedge clk) disable iff (srst)
        s_write_cmd and is_test && cmd_len == CMD_LEN && cmd_data == TEST_MOVE
        |=> test_image == 2'h2)
        else $error("test image not applied");
    a_bad_keep: assert property (@(posedge clk) disable iff (srst)
        s_write_cmd and !data_ok |=> $stable(vbin_enable) && $stable(hbin_enable)
        && $stable(mirror_enable) && $stable(test_image))
        else $error("undefined data code changed a setting");
    a_full_bin: assert property (@(posedge clk) disable iff (srst)
        full_binning == (vbin_enable && hbin_enable))
        else $error("full binning does not match both enables");
    a_reply_flag: assert property (@(posedge clk) disable iff (srst)
        rd_pend && dp_addr == OFS_RSP |-> hrdata[POS_FLAG] == FLAG_WRITE
        && hrdata[POS_LEN +: 8] == CMD_LEN)
        else $error("reply word flag or length wrong");

    // A refused command flags itself and must not touch any setting
    a_reject_flag: assert property (@(posedge clk) disable iff (srst)
        s_reject_cmd |=> reject && $stable(vbin_enable) && $stable(hbin_enable)
        && $stable(mirror_enable) && $stable(test_image))
        else $error("refused command not flagged or changed a setting");
    // The reject flag only tells about the latest command word
    a_accept_clear: assert property (@(posedge clk) disable iff (srst)
        cmd_go && (do_read || apply) |=> !reject)
        else $error("accepted command left the reject flag set");
    // Reading the reply word consumes it, so a stale reply is never flagged valid twice
    a_reply_taken: assert property (@(posedge clk) disable iff (srst)
        s_reply_taken |=> !rsp_valid)
        else $error("reply still pending after it was read");
    // A read command only reports; the settings stay put
    a_read_keeps: assert property (@(posedge clk) disable iff (srst)
        s_read_cmd |=> $stable(vbin_enable) && $stable(hbin_enable)
        && $stable(mirror_enable) && $stable(test_image))
        else $error("read command changed a setting");
    // Mirror off must land as surely as mirror on
    a_mirror_off: assert property (@(posedge clk) disable iff (srst)
        s_write_cmd and is_mirror && cmd_len == CMD_LEN && cmd_data == VAL_OFF
        |=> !mirror_enable)
        else $error("mirror disable not applied");
    // Dropping vertical binning must drop full binning in the same cycle
    a_full_drop: assert property (@(posedge clk) disable iff (srst)
        s_write_cmd and is_vbin && cmd_len == CMD_LEN && cmd_data == VAL_OFF
        |=> !vbin_enable && !full_binning)
        else $error("full binning kept after vertical binning was disabled");
endmodule : ifc_handler
`default_nettype wire

// file: core/ifc_pkg.sv
// Constants for the image feature command handler: command codes, setting codes,
// register offsets, command word field positions and reset values.
// Assumes an AHB-Lite master with 32-bit data that issues single word transfers.
package ifc_pkg;
    // Command codes
    localparam logic [7:0] CODE_VBIN = 8'hA4;
    localparam logic [7:0] CODE_HBIN = 8'hA3;
    localparam logic [7:0] CODE_MIRROR = 8'hC1;
    localparam logic [7:0] CODE_TEST = 8'hA1;
    // Direction flag and the only data length these commands use
    localparam logic FLAG_READ = 1'h1;
    localparam logic FLAG_WRITE = 1'h0;
    localparam logic [7:0] CMD_LEN = 8'h01;
    // Setting codes
    localparam logic [7:0] VAL_OFF = 8'h00;
    localparam logic [7:0] VAL_ON = 8'h01;
    localparam logic [7:0] TEST_NONE = 8'h00;
    localparam logic [7:0] TEST_DIAG = 8'h01;
    localparam logic [7:0] TEST_MOVE = 8'h02;
    localparam logic [7:0] TEST_VH = 8'h03;
    // Register byte offsets
    localparam logic [3:0] OFS_CMD = 4'h0;
    localparam logic [3:0] OFS_RSP = 4'h4;
    localparam logic [3:0] OFS_STAT = 4'h8;
    localparam logic [3:0] OFS_SET = 4'hC;
    // Command and response word fields
    localparam int POS_CODE = 0;
    localparam int POS_FLAG = 8;
    localparam int POS_LEN = 16;
    localparam int POS_DATA = 24;
    // Status and settings bit positions
    localparam int POS_RSP_VALID = 0;
    localparam int POS_REJECT = 1;
    localparam int POS_VBIN = 0;
    localparam int POS_HBIN = 1;
    localparam int POS_MIRROR = 2;
    localparam int POS_FULL = 3;
    localparam int POS_TEST = 4;
    // Reset values
    localparam logic RST_BIN = 1'h0;
    localparam logic RST_MIRROR = 1'h0;
    localparam logic [1:0] RST_TEST = 2'h0;
endpackage : ifc_pkg

// file: test/ifc_host.sv
// Host model: an AHB-Lite master that issues single word transfers for the bench.
// Assumes one slave whose hreadyout is looped back as hready.
`timescale 1ns/100ps
`default_nettype none
module ifc_host
    import ifc_pkg::*;
(
    input wire logic clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // Bus idle at time zero
    initial
    begin
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // One transfer; call right after a rising edge. Ready and read data are looked at
    // in the low half before the edge, so the sample never races that edge's updates.
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        logic rdy;
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do
        begin
            @(negedge clk);
            rdy = hready;
            @(posedge clk);
        end
        while (rdy !== 1'h1);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= wr ? wd : ~hwdata;
        do
        begin
            @(negedge clk);
            rdy = hready;
            rd = hrdata;
            @(posedge clk);
        end
        while (rdy !== 1'h1);
        hwdata <= ~hwdata; // Released data never keeps the last value
    endtask : xfer
endmodule : ifc_host
`default_nettype wire

// file: test/ifc_handler_tb_top.sv
// Bench for the command handler: host model sends commands, ports and registers judged.
// Assumes the register offsets and word layout of the handler package.
`timescale 1ns/100ps
`default_nettype none
module ifc_handler_tb_top
    import ifc_pkg::*;
;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic hsel, hwrite, hreadyout, hresp, vbin_enable, hbin_enable, full_binning, mirror_enable;
    logic [1:0] htrans, test_image;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata;
    int num_errors = 0;
    int checks = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    ifc_handler dut_u (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .vbin_enable(vbin_enable),
        .hbin_enable(hbin_enable), .full_binning(full_binning),
        .mirror_enable(mirror_enable), .test_image(test_image));
    ifc_host host_u (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // Shared compare, register read and command write
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        host_u.xfer(1'h0, a, 32'h0, rd);
        chk(rd, exp);
    endtask : rdc
    task automatic cmd(input logic [7:0] code, input logic flag, input logic [7:0] data);
        logic [31:0] rd;
        host_u.xfer(1'h1, {28'h0, OFS_CMD}, {data, CMD_LEN, 7'h0, flag, code}, rd);
    endtask : cmd
    // Settings as {test, full, mirror, hbin, vbin}, seen at the pins and in SET
    task automatic setx(input logic [5:0] s);
        @(negedge clk);
        chk({25'h0, hresp, test_image, full_binning, mirror_enable, hbin_enable, vbin_enable},
            {26'h0, s});
        @(posedge clk);
        rdc({28'h0, OFS_SET}, {26'h0, s});
    endtask : setx

    task automatic t_reset();
        setx(6'h00);
        rdc({28'h0, OFS_STAT}, 32'h0);
        rdc(32'h10, 32'h0); // Unmapped place reads zero
        $display("test reset done");
    endtask : t_reset

    task automatic t_write();
        cmd(CODE_VBIN, FLAG_WRITE, VAL_ON);
        setx(6'h01);
        cmd(CODE_HBIN, FLAG_WRITE, VAL_ON);
        setx(6'h0B);
        cmd(CODE_MIRROR, FLAG_WRITE, VAL_ON);
        setx(6'h0F);
        cmd(CODE_VBIN, FLAG_WRITE, 8'h02);
        setx(6'h0F);
        rdc({28'h0, OFS_STAT}, 32'h2);
        cmd(CODE_VBIN, FLAG_WRITE, VAL_OFF);
        setx(6'h06);
        for (int i = 0; i < 4; i++)
        begin
            cmd(CODE_TEST, FLAG_WRITE, 8'(i));
            setx({2'(i), 4'h6});
        end
        cmd(CODE_TEST, FLAG_WRITE, 8'h04);
        setx(6'h36);
        rdc({28'h0, OFS_STAT}, 32'h2);
        $display("test write done");
    endtask : t_write

    task automatic t_read();
        logic [7:0] code [4] = '{CODE_VBIN, CODE_HBIN, CODE_MIRROR, CODE_TEST};
        logic [7:0] val [4] = '{VAL_OFF, VAL_ON, VAL_ON, TEST_VH};
        for (int i = 0; i < 4; i++)
        begin
            cmd(code[i], FLAG_READ, 8'h00);
            rdc({28'h0, OFS_STAT}, 32'h1);
            rdc({28'h0, OFS_RSP}, {val[i], CMD_LEN, 7'h0, FLAG_WRITE, code[i]});
            rdc({28'h0, OFS_STAT}, 32'h0);
        end
        setx(6'h36);
        $display("test read done");
    endtask : t_read

    // Refused codes and lengths, the off writes, then a reset in mid-run
    task automatic t_reject();
        logic [31:0] rd;
        logic [31:0] bad_len = {VAL_OFF, 8'h02, 7'h0, FLAG_WRITE, CODE_MIRROR};
        cmd(8'h82, FLAG_WRITE, VAL_ON);
        setx(6'h36);
        rdc({28'h0, OFS_STAT}, 32'h2);
        host_u.xfer(1'h1, {28'h0, OFS_CMD}, bad_len, rd);
        setx(6'h36);
        rdc({28'h0, OFS_STAT}, 32'h2);
        cmd(CODE_MIRROR, FLAG_WRITE, VAL_OFF);
        setx(6'h32);
        rdc({28'h0, OFS_STAT}, 32'h0);
        cmd(CODE_HBIN, FLAG_WRITE, VAL_OFF);
        setx(6'h30);
        cmd(8'h82, FLAG_READ, 8'h00);
        rdc({28'h0, OFS_STAT}, 32'h2);
        cmd(CODE_MIRROR, FLAG_READ, 8'h00);
        // Reset with a reply pending and settings nonzero; both must clear
        srst <= 1'h1;
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        setx(6'h00);
        rdc({28'h0, OFS_STAT}, 32'h0);
        $display("test reject done");
    endtask : t_reject

    task automatic results();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    // Main sequence after five reset cycles
    initial
    begin
        repeat (5) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        t_reset();
        t_write();
        t_read();
        t_reject();
        results();
    end

    // Watchdog, well beyond the roughly 150 cycles the tests need
    initial
    begin
        repeat (4000) @(posedge clk);
        num_errors++;
        results();
    end
endmodule : ifc_handler_tb_top
`default_nettype wire
